// ---- verilog/pme_pkg.sv ----
/*
 Package for the power management event register bank: register
 addresses, bit positions, reset values and the register bus carrier.
 Assumes an 8-bit special function register bus from the core with
 single-cycle read and write strobes.
*/
package pme_pkg;

    localparam logic [7:0] ADDR_EVENT_ENABLE = 8'hec;
    localparam logic [7:0] ADDR_PERIPHERAL_CONFIG_STATUS = 8'hf4;
    localparam logic [7:0] ADDR_BATT_CFG = 8'hf5;
    localparam logic [7:0] ADDR_EVENT_FLAGS = 8'hf8;
    localparam logic [7:0] ADDR_SCRATCH_ONE = 8'hfb;
    localparam logic [7:0] ADDR_INT_PIN_CFG = 8'hff;
    localparam logic [7:0] ADDR_KEY = 8'hc1;
    localparam logic [7:0] ADDR_ADC_START = 8'hd8;
    localparam logic [7:0] KEY_UNLOCK = 8'hea;

    // Bit positions in flags, enables, peripheral register and ADC start register
    localparam int BIT_RESTORED = 7;
    localparam int BIT_SUMMARY = 6;
    localparam int BIT_SAG = 5;
    localparam int BIT_SWITCH = 1;
    localparam int BIT_DC_LOW = 0;
    localparam int BIT_RX_WAKE = 7;
    localparam int BIT_SOURCE = 6;
    localparam int BIT_MAIN_OK = 5;
    localparam int BIT_LOOP_FAULT = 4;
    localparam int BIT_LOOP_ACK = 0;

    // Writable masks, reserved bits stay zero; then the reset values
    localparam logic [7:0] ENABLE_MASK = 8'ha3;
    localparam logic [7:0] FLAG_MASK = 8'he3;
    localparam logic [7:0] BATT_MASK = 8'h03;
    localparam logic [7:0] RESET_ZERO = 8'h00;
    localparam logic [1:0] RX_PIN_RESET = 2'h0;
    localparam logic [1:0] POLICY_RESET = 2'h0;

    typedef enum logic [1:0] {
        POLICY_LOW_MAIN,
        POLICY_LOW_MAIN_OR_DC,
        POLICY_OFF_A,
        POLICY_OFF_B
    } pme_policy_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic bit_wr;
        logic [7:0] addr;
        logic [2:0] bit_sel;
        logic [7:0] wdata;
    } pme_bus_s;

    typedef struct packed {
        logic on_main;
        logic main_ready;
        logic sag;
        logic dc_low;
        logic loop_unlock;
        logic rx_wake;
    } pme_status_s;

endpackage

// ---- verilog/pme_edge.sv ----
/*
 Rising and falling edge detector for one synchronous status level.
 Assumes the level is already synchronous to the core clock.
*/
`timescale 1ns/100ps
module pme_edge
    import pme_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_level,
    input wire logic i_reset_level,
    output logic o_rise,
    output logic o_fall
);

    logic prev;
    logic next_prev;
    logic primed;
    logic next_primed;
    logic seen_prev;

    // Next value of the delayed level; primed once a real sample exists
    always_comb
    begin
        next_prev = i_level;
        next_primed = 1'b1;
    end

    // Delayed copy; reset value is zero, the parent's constant level stands in until primed
    always_ff @(posedge i_core_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            prev <= 1'b0;
            primed <= 1'b0;
        end
        else
        begin
            prev <= next_prev;
            primed <= next_primed;
        end
    end

    // Before the first sample the idle level stands in, so no false edge
    assign seen_prev = primed ? prev : i_reset_level;
    assign o_rise = i_level & ~seen_prev;
    assign o_fall = ~i_level & seen_prev;

endmodule

// ---- verilog/pme_regs.sv ----
/*
 Power management event register bank: event flags, enables,
 switchover policy, peripheral status, scratch pad, key-protected
 interrupt pin configuration.
 Assumes an 8-bit register bus with one-cycle strobes, status levels
 synchronous to i_core_clk, and i_scratch_clear only on total supply loss.
*/
`timescale 1ns/100ps
module pme_regs
    import pme_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_scratch_clear,
    input wire pme_bus_s i_bus,
    input wire pme_status_s i_status,
    output logic [7:0] o_rdata,
    output logic o_event_irq,
    output logic [1:0] o_switch_policy,
    output logic o_switch_on_main_low,
    output logic o_switch_on_dc_low,
    output logic [1:0] o_rx_pin_function,
    output logic [7:0] o_int_pin_config
);

    ////////////////////////////////////////////////////////////////////
    // Register state
    logic [7:0] key_register;
    logic [7:0] event_enable;
    logic [7:0] event_flags;
    logic [1:0] switch_policy;
    logic [1:0] rx_pin_function;
    logic rx_wake_flag;
    logic loop_fault;
    logic [7:0] scratch_pad_one;
    logic [7:0] int_pin_config;
    logic [7:0] rdata;
    logic irq;
    logic [7:0] next_key_register;
    logic [7:0] next_event_enable;
    logic [7:0] next_event_flags;
    logic [1:0] next_switch_policy;
    logic [1:0] next_rx_pin_function;
    logic next_rx_wake_flag;
    logic next_loop_fault;
    logic [7:0] next_scratch_pad_one;
    logic [7:0] next_int_pin_config;
    logic [7:0] next_rdata;
    logic next_irq;
    logic main_low_sel;
    logic dc_low_sel;
    logic next_main_low_sel;
    logic next_dc_low_sel;
    logic [7:0] set_flags;
    logic [7:0] peripheral_view;
    logic src_rise;
    logic src_fall;
    logic unused_fall;

    // Register write hit at a given address
    function automatic logic hit(input pme_bus_s b, input logic [7:0] a);
        hit = b.wr && (b.addr == a);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Supply source edges: to battery and back to main
    pme_edge u_src_edge (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_level(i_status.on_main),
        .i_reset_level(1'b1),
        .o_rise(src_rise),
        .o_fall(src_fall)
    );

    // Sag is treated as a level report; flag on each new cycle with it
    pme_edge u_unused (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_level(1'b0),
        .i_reset_level(1'b0),
        .o_rise(),
        .o_fall(unused_fall)
    );

    ////////////////////////////////////////////////////////////////////
    // Hardware event sources for the flag register
    always_comb
    begin
        set_flags = RESET_ZERO;
        set_flags[BIT_RESTORED] = src_rise;
        set_flags[BIT_SAG] = i_status.sag;
        set_flags[BIT_SWITCH] = src_fall;
        set_flags[BIT_DC_LOW] = i_status.dc_low;
    end

    // Peripheral register as software reads it
    always_comb
    begin
        peripheral_view = RESET_ZERO;
        peripheral_view[BIT_RX_WAKE] = rx_wake_flag;
        peripheral_view[BIT_SOURCE] = i_status.on_main;
        peripheral_view[BIT_MAIN_OK] = i_status.main_ready;
        peripheral_view[BIT_LOOP_FAULT] = loop_fault;
        peripheral_view[1:0] = rx_pin_function;
    end

    ////////////////////////////////////////////////////////////////////
    // Next values of the control registers and flags
    always_comb
    begin
        next_key_register = key_register;
        next_event_enable = event_enable;
        next_event_flags = event_flags;
        next_switch_policy = switch_policy;
        next_rx_pin_function = rx_pin_function;
        next_rx_wake_flag = rx_wake_flag;
        next_loop_fault = loop_fault;
        next_scratch_pad_one = scratch_pad_one;
        next_int_pin_config = int_pin_config;
        if (hit(i_bus, ADDR_KEY))
        begin
            next_key_register = i_bus.wdata;
        end
        if (hit(i_bus, ADDR_INT_PIN_CFG) && key_register == KEY_UNLOCK)
        begin
            next_int_pin_config = i_bus.wdata;
        end
        if (hit(i_bus, ADDR_EVENT_ENABLE))
        begin
            next_event_enable = i_bus.wdata & ENABLE_MASK;
        end
        if (hit(i_bus, ADDR_BATT_CFG))
        begin
            next_switch_policy = i_bus.wdata[1:0] & BATT_MASK[1:0];
        end
        if (hit(i_bus, ADDR_SCRATCH_ONE))
        begin
            next_scratch_pad_one = i_bus.wdata;
        end
        if (hit(i_bus, ADDR_PERIPHERAL_CONFIG_STATUS))
        begin
            next_rx_pin_function = i_bus.wdata[1:0];
        end
        // Software clears flags by writing zero, byte or single bit
        if (hit(i_bus, ADDR_EVENT_FLAGS))
        begin
            next_event_flags = event_flags & i_bus.wdata & FLAG_MASK;
        end
        else if (i_bus.bit_wr && i_bus.addr == ADDR_EVENT_FLAGS
            && !i_bus.wdata[0])
        begin
            next_event_flags[i_bus.bit_sel] = 1'b0;
        end
        if (hit(i_bus, ADDR_ADC_START) && i_bus.wdata[BIT_LOOP_ACK])
        begin
            next_loop_fault = 1'b0;
        end
        // Hardware sets win over software clears
        next_event_flags = next_event_flags | set_flags;
        next_event_flags[BIT_SUMMARY] = next_event_flags[BIT_SUMMARY]
            | (|(next_event_flags & event_enable & ENABLE_MASK));
        if (i_status.loop_unlock)
        begin
            next_loop_fault = 1'b1;
        end
        if (i_status.rx_wake && rx_pin_function == 2'h3)
        begin
            next_rx_wake_flag = 1'b1;
        end
        else if (hit(i_bus, ADDR_PERIPHERAL_CONFIG_STATUS) && !i_bus.wdata[BIT_RX_WAKE])
        begin
            next_rx_wake_flag = 1'b0;
        end
        next_irq = next_event_flags[BIT_SUMMARY];
        next_main_low_sel = ~next_switch_policy[1];
        next_dc_low_sel = (next_switch_policy == 2'h1);
    end

    // Read data selection
    always_comb
    begin
        next_rdata = RESET_ZERO;
        if (i_bus.addr == ADDR_EVENT_ENABLE)
        begin
            next_rdata = event_enable;
        end
        else if (i_bus.addr == ADDR_PERIPHERAL_CONFIG_STATUS)
        begin
            next_rdata = peripheral_view;
        end
        else if (i_bus.addr == ADDR_BATT_CFG)
        begin
            next_rdata = {6'h00, switch_policy};
        end
        else if (i_bus.addr == ADDR_EVENT_FLAGS)
        begin
            next_rdata = event_flags;
        end
        else if (i_bus.addr == ADDR_SCRATCH_ONE)
        begin
            next_rdata = scratch_pad_one;
        end
        else if (i_bus.addr == ADDR_INT_PIN_CFG)
        begin
            next_rdata = int_pin_config;
        end
        else if (i_bus.addr == ADDR_KEY)
        begin
            next_rdata = key_register;
        end
        if (!i_bus.rd)
        begin
            next_rdata = rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Core reset registers
    always_ff @(posedge i_core_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            key_register <= RESET_ZERO;
            event_enable <= RESET_ZERO;
            event_flags <= RESET_ZERO;
            switch_policy <= POLICY_RESET;
            rx_pin_function <= RX_PIN_RESET;
            rx_wake_flag <= 1'b0;
            loop_fault <= 1'b0;
            int_pin_config <= RESET_ZERO;
            rdata <= RESET_ZERO;
            irq <= 1'b0;
            main_low_sel <= 1'b1;
            dc_low_sel <= 1'b0;
        end
        else
        begin
            key_register <= next_key_register;
            event_enable <= next_event_enable;
            event_flags <= next_event_flags;
            switch_policy <= next_switch_policy;
            rx_pin_function <= next_rx_pin_function;
            rx_wake_flag <= next_rx_wake_flag;
            loop_fault <= next_loop_fault;
            int_pin_config <= next_int_pin_config;
            rdata <= next_rdata;
            irq <= next_irq;
            main_low_sel <= next_main_low_sel;
            dc_low_sel <= next_dc_low_sel;
        end
    end

    // Scratch pad survives core reset; only total supply loss clears it
    always_ff @(posedge i_core_clk or posedge i_scratch_clear)
    begin
        if (i_scratch_clear)
        begin
            scratch_pad_one <= RESET_ZERO;
        end
        else
        begin
            scratch_pad_one <= next_scratch_pad_one;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops
    assign o_rdata = rdata;
    assign o_event_irq = irq;
    assign o_switch_policy = switch_policy;
    assign o_switch_on_main_low = main_low_sel;
    assign o_switch_on_dc_low = dc_low_sel;
    assign o_rx_pin_function = rx_pin_function;
    assign o_int_pin_config = int_pin_config;

    ////////////////////////////////////////////////////////////////////
    // Checks
    AST_KEY_LOCK: assert property (@(posedge i_core_clk) disable iff (i_reset)
        key_register != KEY_UNLOCK |=> $stable(int_pin_config))
        else $error("pin config changed while locked");
    AST_RESTORED: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        $rose(i_status.on_main) |=> event_flags[BIT_RESTORED])
        else $error("restored flag missing");
    AST_SUMMARY: assert property (@(posedge i_core_clk) disable iff (i_reset)
        |(event_flags & event_enable) |=> event_flags[BIT_SUMMARY])
        else $error("summary flag missing");
    AST_SAG: assert property (@(posedge i_core_clk) disable iff (i_reset)
        i_status.sag |=> event_flags[BIT_SAG])
        else $error("sag flag missing");
    AST_SWITCH: assert property (@(posedge i_core_clk) disable iff (i_reset)
        $fell(i_status.on_main) |=> event_flags[BIT_SWITCH])
        else $error("switchover flag missing");
    AST_DC_LOW: assert property (@(posedge i_core_clk) disable iff (i_reset)
        i_status.dc_low |=> event_flags[BIT_DC_LOW])
        else $error("dc low flag missing");
    AST_LOOP: assert property (@(posedge i_core_clk) disable iff (i_reset)
        i_status.loop_unlock |=> loop_fault [*1])
        else $error("loop fault not set");
    AST_IRQ: assert property (@(posedge i_core_clk) disable iff (i_reset)
        ##1 o_event_irq == event_flags[BIT_SUMMARY])
        else $error("irq not following summary");
    AST_RESERVED: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        (event_flags & ~FLAG_MASK) == 8'h00)
        else $error("reserved flag bit set");

endmodule

// ---- verif/pme_regs_bench.sv ----
/*
 Self-checking bench for the power event register bank.
 Assumes the one-cycle bus strobes and read timing of pme_regs.
*/
`timescale 1ns/100ps
module pme_regs_bench
    import pme_pkg::*;
;
logic i_core_clk;
logic i_reset;
logic i_scratch_clear;
pme_bus_s bus;
pme_status_s st;
logic [7:0] o_rdata;
logic o_event_irq;
logic [1:0] o_switch_policy;
logic o_switch_on_main_low;
logic o_switch_on_dc_low;
logic [1:0] o_rx_pin_function;
logic [7:0] o_int_pin_config;
int failures = 0;
int checks_done = 0;
int cycles = 0;
integer seed = 32'hb93f;
logic rd_taken;
logic [7:0] exp_q[$];
logic [7:0] rnd;
logic [1:0] fn;
// Status pattern, rest pattern, flags and peripheral readback
localparam logic [5:0] TS [6] = '{6'h38, 6'h34, 6'h10, 6'h30, 6'h20, 6'h30};
localparam logic [5:0] TR [6] = '{6'h30, 6'h30, 6'h10, 6'h30, 6'h20, 6'h30};
localparam logic [7:0] TF [6] = '{8'h20, 8'h01, 8'h02, 8'h80, 8'h00, 8'h00};
localparam logic [7:0] TP [6] = '{8'h60, 8'h60, 8'h20, 8'h60, 8'h40, 8'h60};
// Enable, trigger, flags after trigger, bit to clear, flags after clear
localparam logic [7:0] EN [3] = '{8'h20, 8'h01, 8'h02};
localparam logic [5:0] ES [3] = '{6'h38, 6'h34, 6'h10};
localparam logic [7:0] EF [3] = '{8'h60, 8'h41, 8'hc2};
localparam logic [2:0] EB [3] = '{3'h5, 3'h0, 3'h1};
localparam logic [7:0] EC [3] = '{8'h40, 8'h40, 8'hc0};

pme_regs u_dut (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_scratch_clear(i_scratch_clear),
    .i_bus(bus),
    .i_status(st),
    .o_rdata(o_rdata),
    .o_event_irq(o_event_irq),
    .o_switch_policy(o_switch_policy),
    .o_switch_on_main_low(o_switch_on_main_low),
    .o_switch_on_dc_low(o_switch_on_dc_low),
    .o_rx_pin_function(o_rx_pin_function),
    .o_int_pin_config(o_int_pin_config)
);

////////////////////////////////////////////////////////////////////////
// Clock and hang guard
initial
begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
end

always @(posedge i_core_clk)
begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
        failures++;
        summarize();
    end
end

////////////////////////////////////////////////////////////////////////
// Comparison and verdict
task automatic check(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
        $display("mismatch %s expected %h seen %h", what, exp, seen);
        failures++;
    end
endtask

task automatic summarize();
    if (failures == 0 && checks_done > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
endtask

////////////////////////////////////////////////////////////////////////
// Bus and status drivers, one gap cycle between transfers
task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge i_core_clk);
    bus.wr <= 1'b0;
    // Let the written value settle before a caller looks at outputs
    @(negedge i_core_clk);
endtask

task automatic bwr(input logic [2:0] b, input logic v);
    @(posedge i_core_clk);
    bus.bit_wr <= 1'b1;
    bus.addr <= ADDR_EVENT_FLAGS;
    bus.bit_sel <= b;
    bus.wdata <= {7'h00, v};
    @(posedge i_core_clk);
    bus.bit_wr <= 1'b0;
endtask

task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_core_clk);
    bus.rd <= 1'b1;
    bus.addr <= a;
    exp_q.push_back(e);
    @(posedge i_core_clk);
    bus.rd <= 1'b0;
endtask

task automatic set_st(input logic [5:0] s);
    @(posedge i_core_clk);
    st <= s;
endtask

// Read data watcher: takes the oldest note once a read lands
always @(posedge i_core_clk) rd_taken <= bus.rd;
always @(negedge i_core_clk)
begin
    if (rd_taken === 1'b1)
    begin
        if (exp_q.size() == 0)
            check("read queue", 8'h01, 8'h00);
        else
            check("read data", o_rdata, exp_q.pop_front());
    end
end

////////////////////////////////////////////////////////////////////////
// Main sequence
initial
begin
    i_reset = 1'b1;
    i_scratch_clear = 1'b1;
    bus = '0;
    st = 6'h30;
    repeat (6) @(posedge i_core_clk);
    i_reset <= 1'b0;
    i_scratch_clear <= 1'b0;
    // Reset values and an unmapped address
    rd(ADDR_EVENT_FLAGS, 8'h00);
    rd(ADDR_EVENT_ENABLE, 8'h00);
    rd(ADDR_BATT_CFG, 8'h00);
    rd(ADDR_PERIPHERAL_CONFIG_STATUS, 8'h60);
    rd(ADDR_SCRATCH_ONE, 8'h00);
    rd(8'h80, 8'h00);
    // Every switchover policy code
    for (int p = 0; p < 4; p++)
    begin
        wr(ADDR_BATT_CFG, 8'(p));
        rd(ADDR_BATT_CFG, 8'(p));
        check("policy", {6'h00, o_switch_policy}, 8'(p));
        check("main low", {7'h00, o_switch_on_main_low}, 8'(p < 2));
        check("dc low", {7'h00, o_switch_on_dc_low}, 8'(p == 1));
    end
    wr(ADDR_EVENT_ENABLE, 8'hff);
    rd(ADDR_EVENT_ENABLE, 8'ha3);
    wr(ADDR_EVENT_ENABLE, 8'h00);
    // Each event source with enables off: flag only, no summary
    for (int i = 0; i < 6; i++)
    begin
        set_st(TS[i]);
        set_st(TR[i]);
        repeat (2) @(posedge i_core_clk);
        rd(ADDR_EVENT_FLAGS, TF[i]);
        rd(ADDR_PERIPHERAL_CONFIG_STATUS, TP[i]);
        wr(ADDR_EVENT_FLAGS, 8'h00);
        rd(ADDR_EVENT_FLAGS, 8'h00);
        check("irq idle", {7'h00, o_event_irq}, 8'h00);
    end
    // Enabled sources raise the summary and the request
    for (int i = 0; i < 3; i++)
    begin
        wr(ADDR_EVENT_ENABLE, EN[i]);
        set_st(ES[i]);
        set_st(6'h30);
        repeat (2) @(posedge i_core_clk);
        rd(ADDR_EVENT_FLAGS, EF[i]);
        check("irq set", {7'h00, o_event_irq}, 8'h01);
        bwr(EB[i], 1'b0);
        rd(ADDR_EVENT_FLAGS, EC[i]);
        check("irq held", {7'h00, o_event_irq}, 8'h01);
        wr(ADDR_EVENT_ENABLE, 8'h00);
        bwr(3'h6, 1'b0);
        wr(ADDR_EVENT_FLAGS, 8'h00);
        rd(ADDR_EVENT_FLAGS, 8'h00);
        check("irq clear", {7'h00, o_event_irq}, 8'h01 & 8'h00);
    end
    // Receive pin functions; wake flag only with wake-up enabled
    for (int i = 0; i < 3; i++)
    begin
        fn = (i == 2) ? 2'h3 : 2'(i);
        wr(ADDR_PERIPHERAL_CONFIG_STATUS, {6'h00, fn});
        check("rx pin", {6'h00, o_rx_pin_function}, {6'h00, fn});
        set_st(6'h31);
        set_st(6'h30);
        rd(ADDR_PERIPHERAL_CONFIG_STATUS, {fn == 2'h3, 5'h00, fn} | 8'h60);
    end
    wr(ADDR_PERIPHERAL_CONFIG_STATUS, 8'h00);
    rd(ADDR_PERIPHERAL_CONFIG_STATUS, 8'h60);
    // Lock loss sticks until acknowledged
    set_st(6'h32);
    set_st(6'h30);
    repeat (3) @(posedge i_core_clk);
    rd(ADDR_PERIPHERAL_CONFIG_STATUS, 8'h70);
    wr(ADDR_ADC_START, 8'h01);
    rd(ADDR_PERIPHERAL_CONFIG_STATUS, 8'h60);
    // Key-protected pin configuration
    rnd = 8'($random(seed)) | 8'h01;
    wr(ADDR_INT_PIN_CFG, rnd);
    check("pin cfg", o_int_pin_config, 8'h00);
    wr(ADDR_KEY, 8'heb);
    wr(ADDR_INT_PIN_CFG, rnd);
    check("pin cfg", o_int_pin_config, 8'h00);
    wr(ADDR_KEY, 8'hea);
    wr(ADDR_INT_PIN_CFG, rnd);
    check("pin cfg", o_int_pin_config, rnd);
    rd(ADDR_INT_PIN_CFG, rnd);
    wr(ADDR_KEY, 8'h00);
    wr(ADDR_INT_PIN_CFG, ~rnd);
    check("pin cfg", o_int_pin_config, rnd);
    // Scratch pad survives reset, cleared only by supply loss
    rnd = 8'($random(seed));
    wr(ADDR_SCRATCH_ONE, rnd);
    rd(ADDR_SCRATCH_ONE, rnd);
    @(posedge i_core_clk);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_reset <= 1'b0;
    check("pin cfg", o_int_pin_config, 8'h00);
    rd(ADDR_SCRATCH_ONE, rnd);
    @(posedge i_core_clk);
    i_scratch_clear <= 1'b1;
    @(posedge i_core_clk);
    i_scratch_clear <= 1'b0;
    rd(ADDR_SCRATCH_ONE, 8'h00);
    repeat (3) @(posedge i_core_clk);
    summarize();
end

endmodule
